//--- rtl/maskable_interrupt_acceptance.v
// Maskable interrupt acceptance with per-source control and processor flags
`timescale 1ns/10ps
`include "irq_accept_defines.vh"
module maskable_interrupt_acceptance #(
  parameter ADDR_W = 12,
  parameter NUM_SRC = `IAC_NUM_SRC,
  parameter KEY_W = 4
) (
  input wire ref_clk,
  input wire reset,
  // AXI4-Lite register port
  input wire awvalid,
  output wire awready,
  input wire [ADDR_W-1:0] awaddr,
  input wire [2:0] awprot,
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output wire bvalid,
  input wire bready,
  output wire [1:0] bresp,
  input wire arvalid,
  output wire arready,
  input wire [ADDR_W-1:0] araddr,
  input wire [2:0] arprot,
  output wire rvalid,
  input wire rready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  // One-cycle request pulses from on-chip peripherals
  input wire [NUM_SRC-1:0] periphRequest,
  // Asynchronous request pins
  input wire extPinZeroRequest,
  input wire extPinOneRequest,
  input wire extPinThreeRequest,
  input wire [KEY_W-1:0] keyRequestPins,
  // Processor core side
  input wire trapExec,
  input wire [`IAC_TRAP_W-1:0] trapNumber,
  output wire acceptPulse,
  output wire [`IAC_SRC_W-1:0] acceptSource,
  output wire [`IAC_LVL_W-1:0] acceptLevel,
  output wire globalEnable,
  output wire useMasterStackPtr,
  output wire useTaskStackPtr,
  output wire [`IAC_LVL_W-1:0] cpuPriorityLevel,
  output wire irqLine
);
  // Bus state
  reg awHeldFf;
  reg [ADDR_W-1:0] awAddrFf;
  reg wHeldFf;
  reg [31:0] wDataFf;
  reg [3:0] wStrbFf;
  reg bvalidFf;
  reg [1:0] brespFf;
  reg rvalidFf;
  reg [31:0] rdataFf;
  reg [1:0] rrespFf;

  // Control and flag state
  reg [7:0] ctrlFf [0:NUM_SRC-1];
  reg gieFf;
  reg stackSelFf;
  reg [`IAC_LVL_W-1:0] iplFf;
  reg [`IAC_EVT_W-1:0] statusFf;
  reg [`IAC_EVT_W-1:0] enableFf;
  reg acceptPulseFf;
  reg [`IAC_SRC_W-1:0] acceptSourceFf;
  reg [`IAC_LVL_W-1:0] acceptLevelFf;

  // Pin synchronisers and edge history
  reg [2+KEY_W:0] pinMetaFf;
  reg [2+KEY_W:0] pinSyncFf;
  reg [2+KEY_W:0] pinPrevFf;

  integer i;
  genvar g;

  // Word index of an address, top bit set when the address is aligned and in range
  function [8:0] addrIndex;
    input [ADDR_W-1:0] addr;
    begin
      addrIndex = {1'b0, addr[`IAC_ADDR_IDX_MSB:`IAC_ADDR_IDX_LSB]};
      if ((addr[`IAC_ADDR_IDX_LSB-1:0] == 2'h0) && ((addr >> (`IAC_ADDR_IDX_MSB + 1)) == 0)) begin
        addrIndex[8] = 1'b1;
      end
    end
  endfunction

  // Source number held at a word index, or none for any other index
  function [`IAC_SRC_W-1:0] srcOf;
    input [8:0] ix;
    begin
      srcOf = `IAC_SRC_NONE;
      if (ix[8]) begin
        case (ix[7:0])
          `IAC_IDX_FMRDY: srcOf = 5'h00;
          `IAC_IDX_TMRC: srcOf = 5'h01;
          `IAC_IDX_TMRE: srcOf = 5'h02;
          `IAC_IDX_SER2TX: srcOf = 5'h03;
          `IAC_IDX_SER2RX: srcOf = 5'h04;
          `IAC_IDX_KEY: srcOf = `IAC_SRC_KEY;
          `IAC_IDX_ADC: srcOf = 5'h06;
          `IAC_IDX_SER0TX: srcOf = 5'h07;
          `IAC_IDX_SER0RX: srcOf = 5'h08;
          `IAC_IDX_TMRA: srcOf = 5'h09;
          `IAC_IDX_TMRB: srcOf = 5'h0a;
          `IAC_IDX_PIN1: srcOf = `IAC_SRC_PIN1;
          `IAC_IDX_PIN3: srcOf = `IAC_SRC_PIN3;
          `IAC_IDX_PIN0: srcOf = `IAC_SRC_PIN0;
          `IAC_IDX_COLL: srcOf = 5'h0e;
          `IAC_IDX_VMON1: srcOf = 5'h0f;
          `IAC_IDX_VMON2: srcOf = 5'h10;
          default: srcOf = `IAC_SRC_NONE;
        endcase
      end
    end
  endfunction

  // External pin sources carry edge select bits
  function isExtPin;
    input [`IAC_SRC_W-1:0] src;
    begin
      isExtPin = (src == `IAC_SRC_PIN0) || (src == `IAC_SRC_PIN1) || (src == `IAC_SRC_PIN3);
    end
  endfunction

  // Write side decode
  wire wrFire = awHeldFf && wHeldFf && !bvalidFf;
  wire [8:0] wrIx = addrIndex(awAddrFf);
  wire [`IAC_SRC_W-1:0] wrSrc = srcOf(wrIx);
  wire wrOwnFlag = wrIx[8] && (wrIx[7:0] == `IAC_IDX_FLAG);
  wire wrOwnStatus = wrIx[8] && (wrIx[7:0] == `IAC_IDX_STATUS);
  wire wrOwnEnable = wrIx[8] && (wrIx[7:0] == `IAC_IDX_ENABLE);
  wire wrOwnClear = wrIx[8] && (wrIx[7:0] == `IAC_IDX_CLEAR);
  wire wrMapped = (wrSrc != `IAC_SRC_NONE) || wrOwnFlag || wrOwnStatus || wrOwnEnable ||
                  wrOwnClear;
  wire flagWrLo = wrFire && wrOwnFlag && wStrbFf[0];
  wire flagWrHi = wrFire && wrOwnFlag && wStrbFf[1];

  // Read side decode
  wire rdFire = arvalid && !rvalidFf;
  wire [8:0] rdIx = addrIndex(araddr);
  wire [`IAC_SRC_W-1:0] rdSrc = srcOf(rdIx);

  // Handshake outputs
  assign awready = !awHeldFf;
  assign wready = !wHeldFf;
  assign arready = !rvalidFf;
  assign bvalid = bvalidFf;
  assign bresp = brespFf;
  assign rvalid = rvalidFf;
  assign rdata = rdataFf;
  assign rresp = rrespFf;

  // Write address and data are caught in either order, then applied together
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awHeldFf <= 1'b0;
      awAddrFf <= {ADDR_W{1'b0}};
      wHeldFf <= 1'b0;
      wDataFf <= 32'h0;
      wStrbFf <= 4'h0;
      bvalidFf <= 1'b0;
      brespFf <= `IAC_RESP_OKAY;
    end else begin
      if (awvalid && !awHeldFf) begin
        awHeldFf <= 1'b1;
        awAddrFf <= awaddr;
      end
      if (wvalid && !wHeldFf) begin
        wHeldFf <= 1'b1;
        wDataFf <= wdata;
        wStrbFf <= wstrb;
      end
      if (wrFire) begin
        awHeldFf <= 1'b0;
        wHeldFf <= 1'b0;
        bvalidFf <= 1'b1;
        brespFf <= wrMapped ? `IAC_RESP_OKAY : `IAC_RESP_SLVERR;
      end else if (bvalidFf && bready) begin
        bvalidFf <= 1'b0;
      end
    end
  end

  // Read data mux; reserved bits read as zero
  reg [31:0] rdValue;
  reg rdMapped;
  always @* begin
    rdValue = 32'h0;
    rdMapped = 1'b1;
    if (rdSrc != `IAC_SRC_NONE) begin
      rdValue[7:0] = ctrlFf[rdSrc];
    end else if (rdIx[8] && (rdIx[7:0] == `IAC_IDX_FLAG)) begin
      rdValue[`IAC_FLG_GIE_BIT] = gieFf;
      rdValue[`IAC_FLG_STK_BIT] = stackSelFf;
      rdValue[`IAC_FLG_IPL_MSB:`IAC_FLG_IPL_LSB] = iplFf;
    end else if (rdIx[8] && (rdIx[7:0] == `IAC_IDX_STATUS)) begin
      rdValue[`IAC_EVT_W-1:0] = statusFf;
    end else if (rdIx[8] && (rdIx[7:0] == `IAC_IDX_ENABLE)) begin
      rdValue[`IAC_EVT_W-1:0] = enableFf;
    end else if (rdIx[8] && (rdIx[7:0] == `IAC_IDX_CLEAR)) begin
      rdValue = 32'h0;
    end else begin
      rdMapped = 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rvalidFf <= 1'b0;
      rdataFf <= 32'h0;
      rrespFf <= `IAC_RESP_OKAY;
    end else if (rdFire) begin
      rvalidFf <= 1'b1;
      rdataFf <= rdValue;
      rrespFf <= rdMapped ? `IAC_RESP_OKAY : `IAC_RESP_SLVERR;
    end else if (rvalidFf && rready) begin
      rvalidFf <= 1'b0;
    end
  end

  // Two-stage synchronisers for pins, then one stage of history for edges
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinMetaFf <= {(3+KEY_W){1'b1}};
      pinSyncFf <= {(3+KEY_W){1'b1}};
      pinPrevFf <= {(3+KEY_W){1'b1}};
    end else begin
      pinMetaFf <= {keyRequestPins, extPinThreeRequest, extPinOneRequest, extPinZeroRequest};
      pinSyncFf <= pinMetaFf;
      pinPrevFf <= pinSyncFf;
    end
  end

  wire [2+KEY_W:0] pinRise = pinSyncFf & ~pinPrevFf;
  wire [2+KEY_W:0] pinFall = ~pinSyncFf & pinPrevFf;

  // Edge choice per pin: bit 5 both edges, else bit 4 picks rising over falling
  function pinEdge;
    input [7:0] ctl;
    input rise;
    input fall;
    begin
      if (ctl[`IAC_CTL_BOTH_BIT]) begin
        pinEdge = rise | fall;
      end else begin
        pinEdge = ctl[`IAC_CTL_POL_BIT] ? rise : fall;
      end
    end
  endfunction

  // Request events per source: peripheral pulses plus pin edges
  reg [NUM_SRC-1:0] reqSet;
  always @* begin
    reqSet = periphRequest;
    reqSet[`IAC_SRC_PIN0] = periphRequest[`IAC_SRC_PIN0] |
                            pinEdge(ctrlFf[`IAC_SRC_PIN0], pinRise[0], pinFall[0]);
    reqSet[`IAC_SRC_PIN1] = periphRequest[`IAC_SRC_PIN1] |
                            pinEdge(ctrlFf[`IAC_SRC_PIN1], pinRise[1], pinFall[1]);
    reqSet[`IAC_SRC_PIN3] = periphRequest[`IAC_SRC_PIN3] |
                            pinEdge(ctrlFf[`IAC_SRC_PIN3], pinRise[2], pinFall[2]);
    reqSet[`IAC_SRC_KEY] = periphRequest[`IAC_SRC_KEY] | (|pinFall[2+KEY_W:3]);
  end

  // Pack levels and pending flags for the picker
  wire [NUM_SRC*`IAC_LVL_W-1:0] levelsPacked;
  wire [NUM_SRC-1:0] pendingFlags;
  wire [NUM_SRC-1:0] ctrlWrHit;
  wire [NUM_SRC-1:0] acceptHit;
  wire [`IAC_LVL_W-1:0] bestLevel;
  wire [`IAC_SRC_W-1:0] bestIndex;
  wire acceptNow;

  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : srcLane
      localparam [31:0] SRC_FULL = g;
      localparam [`IAC_SRC_W-1:0] SRC = SRC_FULL[`IAC_SRC_W-1:0];
      assign levelsPacked[g*`IAC_LVL_W +: `IAC_LVL_W] = ctrlFf[g][`IAC_CTL_LVL_MSB:0];
      assign pendingFlags[g] = ctrlFf[g][`IAC_CTL_REQ_BIT];
      assign ctrlWrHit[g] = wrFire && wStrbFf[0] && (wrSrc == SRC);
      assign acceptHit[g] = acceptNow && (bestIndex == SRC);
    end
  endgenerate

  irq_priority_pick #(
    .NUM_SRC(NUM_SRC)
  ) picker (
    .levels(levelsPacked),
    .pending(pendingFlags),
    .bestLevel(bestLevel),
    .bestIndex(bestIndex)
  );

  // Take the winner only while enabled and strictly above the current level
  assign acceptNow = gieFf && (bestLevel > iplFf);
  wire trapMaster = trapExec && (trapNumber <= `IAC_TRAP_LAST);

  // Control registers; a new request wins over a clear by write or by acceptance
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < NUM_SRC; i = i + 1) begin
        ctrlFf[i] <= `IAC_CTL_RESET;
      end
    end else begin
      for (i = 0; i < NUM_SRC; i = i + 1) begin
        if (ctrlWrHit[i]) begin
          ctrlFf[i][`IAC_CTL_LVL_MSB:0] <= wDataFf[`IAC_CTL_LVL_MSB:0];
          if (isExtPin(i[`IAC_SRC_W-1:0])) begin
            ctrlFf[i][`IAC_CTL_POL_BIT] <= wDataFf[`IAC_CTL_POL_BIT];
            ctrlFf[i][`IAC_CTL_BOTH_BIT] <= wDataFf[`IAC_CTL_BOTH_BIT];
          end
        end
        ctrlFf[i][`IAC_CTL_REQ_BIT] <= reqSet[i] | (ctrlFf[i][`IAC_CTL_REQ_BIT] &
          ~(ctrlWrHit[i] & ~wDataFf[`IAC_CTL_REQ_BIT]) & ~acceptHit[i]);
      end
    end
  end

  // Processor flags; hardware updates win over a software write in the same cycle
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gieFf <= 1'b0;
      stackSelFf <= 1'b0;
      iplFf <= {`IAC_LVL_W{1'b0}};
    end else begin
      if (acceptNow) begin
        gieFf <= 1'b0;
      end else if (flagWrLo) begin
        gieFf <= wDataFf[`IAC_FLG_GIE_BIT];
      end
      if (acceptNow || trapMaster) begin
        stackSelFf <= 1'b0;
      end else if (flagWrLo) begin
        stackSelFf <= wDataFf[`IAC_FLG_STK_BIT];
      end
      if (acceptNow) begin
        iplFf <= bestLevel;
      end else if (flagWrHi) begin
        iplFf <= wDataFf[`IAC_FLG_IPL_MSB:`IAC_FLG_IPL_LSB];
      end
    end
  end

  // Acceptance report to the core, one pulse per taken request
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acceptPulseFf <= 1'b0;
      acceptSourceFf <= `IAC_SRC_NONE;
      acceptLevelFf <= {`IAC_LVL_W{1'b0}};
    end else begin
      acceptPulseFf <= acceptNow;
      if (acceptNow) begin
        acceptSourceFf <= bestIndex;
        acceptLevelFf <= bestLevel;
      end
    end
  end

  // Sticky event status; a new event wins over a clear
  wire [`IAC_EVT_W-1:0] evtNow = {trapExec, acceptNow};
  wire [`IAC_EVT_W-1:0] evtClr = (wrFire && wrOwnClear && wStrbFf[0]) ?
                                 wDataFf[`IAC_EVT_W-1:0] : {`IAC_EVT_W{1'b0}};
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      statusFf <= {`IAC_EVT_W{1'b0}};
      enableFf <= {`IAC_EVT_W{1'b0}};
    end else begin
      statusFf <= evtNow | (statusFf & ~evtClr);
      if (wrFire && wrOwnEnable && wStrbFf[0]) begin
        enableFf <= wDataFf[`IAC_EVT_W-1:0];
      end
    end
  end

  // Core-facing outputs
  assign acceptPulse = acceptPulseFf;
  assign acceptSource = acceptSourceFf;
  assign acceptLevel = acceptLevelFf;
  assign globalEnable = gieFf;
  assign useMasterStackPtr = !stackSelFf;
  assign useTaskStackPtr = stackSelFf;
  assign cpuPriorityLevel = iplFf;
  assign irqLine = |(statusFf & enableFf);
endmodule

//--- inc/irq_accept_defines.vh
// Constants for the maskable interrupt acceptance block
//
// Contract
// - While the global enable flag is 0 no maskable request is taken; while it is 1 they can be.
// - Taking any request clears the global enable flag to 0 until software sets it again.
// - Stack choice flag 0 selects the master stack pointer, 1 selects the task stack pointer.
// - Stack choice flag clears on a taken hardware request and on a trap numbered 0 to 31.
// - The processor priority level is a three-bit field holding levels 0 to 7.
// - A request is taken only if its level is strictly above the processor priority level.
// - Reserved flag bits should be written 0 and their read value is not to be relied on.
// - Each of the seventeen sources owns its own control register.
// - Reset clears control bits 2:0 everywhere, and also bits 4 and 5 in external pin registers.
`ifndef IRQ_ACCEPT_DEFINES_VH
`define IRQ_ACCEPT_DEFINES_VH

// Source count and level width
`define IAC_NUM_SRC 17
`define IAC_LVL_W 3
`define IAC_SRC_W 5
`define IAC_SRC_NONE 5'h1f

// Control register fields
`define IAC_CTL_LVL_MSB 2
`define IAC_CTL_REQ_BIT 3
`define IAC_CTL_POL_BIT 4
`define IAC_CTL_BOTH_BIT 5
`define IAC_CTL_RESET 8'h00

// Register indices; byte address is four times the index
`define IAC_IDX_FMRDY 8'h41
`define IAC_IDX_TMRC 8'h47
`define IAC_IDX_TMRE 8'h4a
`define IAC_IDX_SER2TX 8'h4b
`define IAC_IDX_SER2RX 8'h4c
`define IAC_IDX_KEY 8'h4d
`define IAC_IDX_ADC 8'h4e
`define IAC_IDX_SER0TX 8'h51
`define IAC_IDX_SER0RX 8'h52
`define IAC_IDX_TMRA 8'h56
`define IAC_IDX_TMRB 8'h58
`define IAC_IDX_PIN1 8'h59
`define IAC_IDX_PIN3 8'h5a
`define IAC_IDX_PIN0 8'h5d
`define IAC_IDX_COLL 8'h5e
`define IAC_IDX_VMON1 8'h72
`define IAC_IDX_VMON2 8'h73
`define IAC_IDX_FLAG 8'h90
`define IAC_IDX_STATUS 8'h91
`define IAC_IDX_ENABLE 8'h92
`define IAC_IDX_CLEAR 8'h93

// Source numbers, also the fixed tie order
`define IAC_SRC_KEY 5'h05
`define IAC_SRC_PIN1 5'h0b
`define IAC_SRC_PIN3 5'h0c
`define IAC_SRC_PIN0 5'h0d

// Processor flag register fields
`define IAC_FLG_GIE_BIT 0
`define IAC_FLG_STK_BIT 1
`define IAC_FLG_IPL_LSB 8
`define IAC_FLG_IPL_MSB 10

// Event status bits
`define IAC_EVT_W 2
`define IAC_EVT_ACCEPT 0
`define IAC_EVT_TRAP 1

// Trap numbers that switch to the master stack
`define IAC_TRAP_W 6
`define IAC_TRAP_LAST 6'h1f

// Bus answers
`define IAC_RESP_OKAY 2'h0
`define IAC_RESP_SLVERR 2'h2
`define IAC_ADDR_IDX_LSB 2
`define IAC_ADDR_IDX_MSB 9

`endif

//--- rtl/irq_priority_pick.v
// Picks the highest-level pending source, lowest number winning ties
`timescale 1ns/10ps
`include "irq_accept_defines.vh"
module irq_priority_pick #(
  parameter NUM_SRC = `IAC_NUM_SRC
) (
  input wire [NUM_SRC*`IAC_LVL_W-1:0] levels,
  input wire [NUM_SRC-1:0] pending,
  output reg [`IAC_LVL_W-1:0] bestLevel,
  output reg [`IAC_SRC_W-1:0] bestIndex
);
  integer i;

  // Strict compare keeps the earlier source on equal level; level 0 never wins
  always @* begin
    bestLevel = {`IAC_LVL_W{1'b0}};
    bestIndex = `IAC_SRC_NONE;
    for (i = 0; i < NUM_SRC; i = i + 1) begin
      if (pending[i] && (levels[i*`IAC_LVL_W +: `IAC_LVL_W] > bestLevel)) begin
        bestLevel = levels[i*`IAC_LVL_W +: `IAC_LVL_W];
        bestIndex = i[`IAC_SRC_W-1:0];
      end
    end
  end
endmodule

//--- bench/irq_accept_checker.sv
// Concurrent checks on the acceptance and flag outputs
`timescale 1ns/10ps
module irq_accept_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic trapExec,
  input wire logic [5:0] trapNumber,
  input wire logic acceptPulse,
  input wire logic [2:0] acceptLevel,
  input wire logic globalEnable,
  input wire logic useMasterStackPtr,
  input wire logic useTaskStackPtr,
  input wire logic [2:0] cpuPriorityLevel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // A taken request, and a trap that must fall back to the master stack
  sequence s_take;
    acceptPulse;
  endsequence
  sequence s_low_trap;
    trapExec && trapNumber <= 6'h1f;
  endsequence
  // Acceptance needs the enable flag and a strictly higher level
  a_take_enabled: assert property (s_take |-> $past(globalEnable))
    else $error("request taken while disabled");
  a_take_masks: assert property (s_take |-> !globalEnable)
    else $error("enable flag still set after a take");
  a_take_once: assert property (s_take |=> !acceptPulse)
    else $error("second take without re-enable");
  a_level_above: assert property (s_take |-> acceptLevel > $past(cpuPriorityLevel))
    else $error("taken level not above processor level");
  a_level_loaded: assert property (s_take |-> cpuPriorityLevel == acceptLevel)
    else $error("processor level not loaded");
  a_level_nonzero: assert property (s_take |-> acceptLevel != 3'h0)
    else $error("level zero source taken");
  // Stack choice
  a_stack_exclusive: assert property (useMasterStackPtr != useTaskStackPtr)
    else $error("stack selects not exclusive");
  a_take_stack: assert property (s_take |-> useMasterStackPtr)
    else $error("take left task stack selected");
  a_trap_stack: assert property (s_low_trap |=> useMasterStackPtr)
    else $error("low trap left task stack selected");
endmodule

//--- bench/irq_source_model.sv
// Model of the peripheral sources, request pins and the core's trap strobe
`timescale 1ns/10ps
module irq_source_model (
  input wire logic ref_clk,
  output logic [16:0] periphRequest,
  output logic [3:0] pinLevels,
  output logic trapExec,
  output logic [5:0] trapNumber
);
  // Idle state: no pulses, pins pulled high
  initial begin
    periphRequest = 17'h0;
    pinLevels = 4'hf;
    trapExec = 1'h0;
    trapNumber = 6'h2a;
  end
  // One-cycle request pulse on the given sources
  task pulse(input [16:0] m);
    @(posedge ref_clk);
    periphRequest <= m;
    @(posedge ref_clk);
    periphRequest <= 17'h0;
  endtask
  // Pin held low for three cycles, then back high
  task drop(input [1:0] k);
    @(posedge ref_clk);
    pinLevels[k] <= 1'h0;
    repeat (3) @(posedge ref_clk);
    pinLevels[k] <= 1'h1;
  endtask
  // Trap strobe; number goes stale afterwards
  task trap(input [5:0] n);
    @(posedge ref_clk);
    trapExec <= 1'h1;
    trapNumber <= n;
    @(posedge ref_clk);
    trapExec <= 1'h0;
    trapNumber <= ~n;
  endtask
endmodule

//--- bench/maskable_interrupt_acceptance_tb_top.sv
// Register-level testbench for the maskable interrupt acceptance block
`timescale 1ns/10ps
`include "irq_accept_defines.vh"
module maskable_interrupt_acceptance_tb_top;
  logic ref_clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb, strb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  wire awready, wready, bvalid, arready, rvalid, trapExec;
  wire acceptPulse, globalEnable, useMasterStackPtr, useTaskStackPtr, irqLine;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [16:0] periphRequest;
  wire [3:0] pinLevels;
  wire [5:0] trapNumber;
  wire [4:0] acceptSource;
  wire [2:0] acceptLevel, cpuPriorityLevel;
  integer errors, num_checks, takes, i;
  logic [7:0] ctlIdx [17];
  maskable_interrupt_acceptance DUT (.ref_clk, .reset, .awvalid, .awready, .awaddr,
    .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp,
    .periphRequest, .extPinZeroRequest(pinLevels[0]), .extPinOneRequest(pinLevels[1]),
    .extPinThreeRequest(pinLevels[2]), .keyRequestPins({4{pinLevels[3]}}), .trapExec,
    .trapNumber, .acceptPulse, .acceptSource, .acceptLevel, .globalEnable,
    .useMasterStackPtr, .useTaskStackPtr, .cpuPriorityLevel, .irqLine);
  irq_source_model SRC (.ref_clk, .periphRequest, .pinLevels, .trapExec, .trapNumber);
  // Clock
  always #10 ref_clk = ~ref_clk;
  // Count taken requests
  always @(posedge ref_clk) if (acceptPulse === 1'h1) takes <= takes + 1;
  task check(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task guard(input integer n);
    if (n > 60) begin
      errors++;
      $display("[FAIL] t=%0t bus wait timed out", $time);
      tally_and_finish;
    end
  endtask
  // Bus write, address and data offered together, each released at the edge that takes it
  task wr(input [7:0] ix, input [31:0] d, input [1:0] er);
    integer n;
    logic awTk, wTk, done;
    logic [1:0] resp;
    @(posedge ref_clk);
    awvalid <= 1'h1;
    awaddr <= {2'h0, ix, 2'h0};
    awprot <= 3'h2;
    wvalid <= 1'h1;
    wdata <= d;
    wstrb <= strb;
    bready <= 1'h1;
    n = 0;
    done = 1'h0;
    while (!done) begin
      // Handshakes are settled at the falling edge before the sampling edge
      @(negedge ref_clk);
      n++;
      guard(n);
      awTk = awvalid && (awready === 1'h1);
      wTk = wvalid && (wready === 1'h1);
      done = (bvalid === 1'h1);
      resp = bresp;
      @(posedge ref_clk);
      if (awTk) awvalid <= 1'h0;
      if (wTk) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    check(resp, er);
  endtask
  // Bus read with expected data and response, answer taken at the edge with rready
  task rd(input [7:0] ix, input [31:0] ed, input [1:0] er);
    integer n;
    logic arTk, done;
    logic [31:0] data;
    logic [1:0] resp;
    @(posedge ref_clk);
    arvalid <= 1'h1;
    araddr <= {2'h0, ix, 2'h0};
    arprot <= 3'h2;
    rready <= 1'h1;
    n = 0;
    done = 1'h0;
    while (!done) begin
      @(negedge ref_clk);
      n++;
      guard(n);
      arTk = arvalid && (arready === 1'h1);
      done = (rvalid === 1'h1);
      data = rdata;
      resp = rresp;
      @(posedge ref_clk);
      if (arTk) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    check(data, ed);
    check(resp, er);
  endtask
  task idle(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task take(input integer cnt, input [4:0] src, input [2:0] lvl);
    check(takes, cnt);
    check(acceptSource, src);
    check(acceptLevel, lvl);
    check(cpuPriorityLevel, lvl);
  endtask
  // Main sequence
  initial begin
    ref_clk = 1'h0;
    reset = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awprot = 3'h0;
    arprot = 3'h0;
    wstrb = 4'hf;
    strb = 4'hf;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    errors = 0;
    num_checks = 0;
    takes = 0;
    ctlIdx = '{`IAC_IDX_FMRDY, `IAC_IDX_TMRC, `IAC_IDX_TMRE, `IAC_IDX_SER2TX,
      `IAC_IDX_SER2RX, `IAC_IDX_KEY, `IAC_IDX_ADC, `IAC_IDX_SER0TX, `IAC_IDX_SER0RX,
      `IAC_IDX_TMRA, `IAC_IDX_TMRB, `IAC_IDX_PIN1, `IAC_IDX_PIN3, `IAC_IDX_PIN0,
      `IAC_IDX_COLL, `IAC_IDX_VMON1, `IAC_IDX_VMON2};
    repeat (12) @(posedge ref_clk);
    reset <= 1'h0;
    // Control registers: reset value and writable fields
    for (i = 0; i < 17; i++) begin
      rd(ctlIdx[i], 32'h0, 2'h0);
      wr(ctlIdx[i], 32'hff, 2'h0);
      rd(ctlIdx[i], (i >= 11 && i <= 13) ? 32'h37 : 32'h07, 2'h0);
      wr(ctlIdx[i], 32'h0, 2'h0);
    end
    rd(`IAC_IDX_FLAG, 32'h0, 2'h0);
    check(useMasterStackPtr, 1'h1);
    rd(8'h3f, 32'h0, `IAC_RESP_SLVERR);
    wr(8'h3f, 32'h0, `IAC_RESP_SLVERR);
    // Pending request held off until enabled, then taken
    wr(ctlIdx[3], 32'h05, 2'h0);
    wr(`IAC_IDX_ENABLE, 32'h1, 2'h0);
    SRC.pulse(17'h8);
    idle(4);
    check(takes, 0);
    rd(ctlIdx[3], 32'h0d, 2'h0);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    idle(3);
    take(1, 5'h03, 3'h5);
    check(globalEnable, 1'h0);
    rd(ctlIdx[3], 32'h05, 2'h0);
    // Interrupt line: set, masked, cleared
    idle(2);
    check(irqLine, 1'h1);
    wr(`IAC_IDX_ENABLE, 32'h0, 2'h0);
    idle(2);
    check(irqLine, 1'h0);
    wr(`IAC_IDX_ENABLE, 32'h1, 2'h0);
    idle(2);
    check(irqLine, 1'h1);
    wr(`IAC_IDX_CLEAR, 32'h1, 2'h0);
    idle(2);
    check(irqLine, 1'h0);
    rd(`IAC_IDX_STATUS, 32'h0, 2'h0);
    rd(`IAC_IDX_CLEAR, 32'h0, 2'h0);
    // Equal level refused, raised level taken
    wr(ctlIdx[0], 32'h05, 2'h0);
    SRC.pulse(17'h1);
    wr(`IAC_IDX_FLAG, 32'h501, 2'h0);
    idle(4);
    check(takes, 1);
    wr(ctlIdx[0], 32'h0e, 2'h0);
    idle(3);
    take(2, 5'h00, 3'h6);
    // Several pending at once: level first, then source order
    wr(ctlIdx[2], 32'h04, 2'h0);
    wr(ctlIdx[7], 32'h04, 2'h0);
    wr(ctlIdx[9], 32'h02, 2'h0);
    SRC.pulse(17'h286);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    idle(3);
    take(3, 5'h02, 3'h4);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    idle(3);
    take(4, 5'h07, 3'h4);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    idle(3);
    take(5, 5'h09, 3'h2);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    idle(3);
    check(takes, 5);
    // Stack choice and traps
    wr(`IAC_IDX_FLAG, 32'h2, 2'h0);
    idle(2);
    check(useTaskStackPtr, 1'h1);
    SRC.trap(6'h20);
    idle(2);
    check(useTaskStackPtr, 1'h1);
    SRC.trap(6'h1f);
    idle(2);
    check(useMasterStackPtr, 1'h1);
    rd(`IAC_IDX_STATUS, 32'h3, 2'h0);
    // Pin request taken from the task stack, then key request taken from the master stack
    wr(ctlIdx[13], 32'h03, 2'h0);
    wr(`IAC_IDX_FLAG, 32'h3, 2'h0);
    SRC.drop(2'h0);
    idle(6);
    take(6, 5'h0d, 3'h3);
    check(useMasterStackPtr, 1'h1);
    wr(ctlIdx[5], 32'h02, 2'h0);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    SRC.drop(2'h3);
    idle(6);
    take(7, 5'h05, 3'h2);
    // Lane strobes: only the level byte of the flag word is written
    strb = 4'h2;
    wr(`IAC_IDX_FLAG, 32'h701, 2'h0);
    strb = 4'hf;
    rd(`IAC_IDX_FLAG, 32'h700, 2'h0);
    // Both edges on one pin, then rising edge only on another
    wr(ctlIdx[12], 32'h24, 2'h0);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    SRC.drop(2'h2);
    idle(6);
    take(8, 5'h0c, 3'h4);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    idle(3);
    take(9, 5'h0c, 3'h4);
    wr(ctlIdx[11], 32'h16, 2'h0);
    wr(`IAC_IDX_FLAG, 32'h1, 2'h0);
    SRC.drop(2'h1);
    idle(6);
    take(10, 5'h0b, 3'h6);
    tally_and_finish;
  end
endmodule
bind maskable_interrupt_acceptance irq_accept_checker chk (.ref_clk, .reset, .trapExec,
  .trapNumber, .acceptPulse, .acceptLevel, .globalEnable, .useMasterStackPtr,
  .useTaskStackPtr, .cpuPriorityLevel);
